// file: hw/scr_pkg.sv
// package: register map, field layout and reset values of the switch config bank
package scr_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [15:0] SCR_IDX_RX_K_VALUE = 16'hF168;
  localparam logic [15:0] SCR_IDX_RX_M_REQUIRED = 16'hF169;
  localparam logic [15:0] SCR_IDX_RX_M_BLANK = 16'hF16A;
  localparam logic [15:0] SCR_IDX_RX_DELAY_LENGTH = 16'hF16B;
  localparam logic [15:0] SCR_IDX_SWITCH_CFG = 16'hF400;

  localparam int SCR_ADDR_W = 18;
  localparam int SCR_DATA_W = 16;

  // reset values
  localparam logic [15:0] SCR_RST_RX_K_VALUE = 16'h0040;
  localparam logic [15:0] SCR_RST_RX_M_REQUIRED = 16'h0000;
  localparam logic [15:0] SCR_RST_RX_M_BLANK = 16'h0002;
  localparam logic [15:0] SCR_RST_SWITCH_CFG = 16'h0000;
  localparam logic [5:0] SCR_RST_DELAY_LENGTH = 6'h00;

  // switch config field positions
  localparam int SCR_POS_SWITCH_ENABLE = 15;
  localparam int SCR_POS_PORT_DIS_LO = 8;
  localparam int SCR_NUM_PORTS = 7;
  localparam int SCR_POS_HARD_RESET = 1;
  localparam int SCR_POS_SOFT_RESET = 0;
  localparam int SCR_DELAY_LEN_W = 6;

  // writable bits of the switch config word
  localparam logic [15:0] SCR_CFG_WR_MASK = 16'hFF03;

  // cycles a reset strobe is held before the self-clearing bit drops
  localparam logic [3:0] SCR_RESET_PULSE_CYCLES = 4'h4;

  // register selector
  typedef enum {
    SCR_SEL_K_VALUE,
    SCR_SEL_M_REQUIRED,
    SCR_SEL_M_BLANK,
    SCR_SEL_DELAY_LENGTH,
    SCR_SEL_SWITCH_CFG,
    SCR_SEL_NONE
  } scr_sel_e;

  // settings handed to the delay unit
  typedef struct packed {
    logic [15:0] k_value;
    logic [15:0] m_required;
    logic [15:0] m_blank;
  } scr_delay_cfg_s;

  // controls handed to the switch core
  typedef struct packed {
    logic switch_enable;
    logic [6:0] port_enable;
    logic hard_reset;
    logic soft_reset;
  } scr_core_ctl_s;

endpackage : scr_pkg

// file: hw/scr_reset_seq.sv
// reset sequencer: stretches a self-clearing reset request into a strobe
`timescale 1ns/10ps
module scr_reset_seq
  import scr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic start_i,
  output logic active_o,
  output logic done_o
);

  typedef enum {SCR_RS_IDLE, SCR_RS_RUN, SCR_RS_DONE} scr_rs_state_e;

  scr_rs_state_e state;
  scr_rs_state_e next_state;
  logic [3:0] count;
  logic [3:0] next_count;

  // next-state logic
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      SCR_RS_IDLE: begin
        if (start_i) begin
          next_state = SCR_RS_RUN;
          next_count = SCR_RESET_PULSE_CYCLES;
        end
      end
      SCR_RS_RUN: begin
        next_count = count - 4'h1;
        if (count == 4'h1) begin
          next_state = SCR_RS_DONE;
        end
      end
      SCR_RS_DONE: begin
        next_state = SCR_RS_IDLE;
      end
      default: begin
        next_state = SCR_RS_IDLE;
      end
    endcase
  end

  // state registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= SCR_RS_IDLE;
      count <= 4'h0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign active_o = (state == SCR_RS_RUN);
  assign done_o = (state == SCR_RS_DONE);

endmodule : scr_reset_seq

// file: hw/scr_switch_cfg_regs.sv
// switch configuration and receive delay-path register bank on avalon-mm
`timescale 1ns/10ps
module scr_switch_cfg_regs
  import scr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // avalon-mm slave, byte addressed
  input wire logic [SCR_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  // delay unit status, from logic on the same clock
  input wire logic [SCR_DELAY_LEN_W-1:0] rx_delay_length_i,
  input wire logic rx_delay_length_valid_i,
  // outputs to delay unit and switch core
  output scr_delay_cfg_s rx_delay_cfg_o,
  output scr_core_ctl_s core_ctl_o
);

  // address decode from a byte address to a register selector
  function automatic scr_sel_e decode(input logic [SCR_ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = addr[SCR_ADDR_W-1:2];
    if (addr[1:0] != 2'h0) begin
      decode = SCR_SEL_NONE;
    end else if (idx == SCR_IDX_RX_K_VALUE) begin
      decode = SCR_SEL_K_VALUE;
    end else if (idx == SCR_IDX_RX_M_REQUIRED) begin
      decode = SCR_SEL_M_REQUIRED;
    end else if (idx == SCR_IDX_RX_M_BLANK) begin
      decode = SCR_SEL_M_BLANK;
    end else if (idx == SCR_IDX_RX_DELAY_LENGTH) begin
      decode = SCR_SEL_DELAY_LENGTH;
    end else if (idx == SCR_IDX_SWITCH_CFG) begin
      decode = SCR_SEL_SWITCH_CFG;
    end else begin
      decode = SCR_SEL_NONE;
    end
  endfunction : decode

  // merge the low 16 bits of a write under byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old_val, input logic [31:0] wdata,
                                          input logic [3:0] be);
    merge16[7:0] = be[0] ? wdata[7:0] : old_val[7:0];
    merge16[15:8] = be[1] ? wdata[15:8] : old_val[15:8];
  endfunction : merge16

  // bus handshake state
  typedef enum {SCR_BUS_IDLE, SCR_BUS_ACK} scr_bus_state_e;

  scr_bus_state_e bus_state;
  scr_bus_state_e next_bus_state;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] resp;
  logic [1:0] next_resp;

  // register contents
  logic [15:0] k_value;
  logic [15:0] next_k_value;
  logic [15:0] m_required;
  logic [15:0] next_m_required;
  logic [15:0] m_blank;
  logic [15:0] next_m_blank;
  logic [15:0] switch_cfg;
  logic [15:0] next_switch_cfg;
  logic [SCR_DELAY_LEN_W-1:0] delay_length;
  logic [SCR_DELAY_LEN_W-1:0] next_delay_length;

  // internal reset from the hard reset sequence
  logic bank_rst;
  logic hard_active;
  logic hard_done;
  logic soft_active;
  logic soft_done;
  logic hard_start;
  logic soft_start;

  scr_sel_e sel;
  logic wr_go;
  logic [15:0] wr_cfg;
  logic cfg_wr;
  logic hard_set;
  logic soft_set;
  logic soft_seq_rst;

  assign sel = decode(avs_address_i);
  // a write is committed at the edge where waitrequest is low
  assign wr_go = avs_write_i && (bus_state == SCR_BUS_ACK);
  assign wr_cfg = merge16(switch_cfg, avs_writedata_i, avs_byteenable_i);

  // software writes of one to the self-clearing bits; these beat a clear in the same cycle
  assign cfg_wr = wr_go && (sel == SCR_SEL_SWITCH_CFG);
  assign hard_set = cfg_wr && wr_cfg[SCR_POS_HARD_RESET];
  assign soft_set = cfg_wr && wr_cfg[SCR_POS_SOFT_RESET];

  // one wait state per access: the first cycle latches read data and response,
  // the second drops waitrequest so the master samples a settled answer
  // accesses served whether or not switching runs
  always_comb begin
    next_bus_state = SCR_BUS_IDLE;
    next_rdata = rdata;
    next_resp = resp;
    case (bus_state)
      SCR_BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          next_bus_state = SCR_BUS_ACK;
          next_resp = (sel == SCR_SEL_NONE) ? 2'h3 : 2'h0;
          next_rdata = 32'h0000_0000; // upper bits read zero
          case (sel)
            SCR_SEL_K_VALUE: next_rdata[15:0] = k_value;
            SCR_SEL_M_REQUIRED: next_rdata[15:0] = m_required;
            SCR_SEL_M_BLANK: next_rdata[15:0] = m_blank;
            SCR_SEL_DELAY_LENGTH: next_rdata[SCR_DELAY_LEN_W-1:0] = delay_length;
            SCR_SEL_SWITCH_CFG: next_rdata[15:0] = switch_cfg;
            default: next_rdata = 32'h0000_0000;
          endcase
        end
      end
      SCR_BUS_ACK: begin
        next_bus_state = SCR_BUS_IDLE;
      end
      default: begin
        next_bus_state = SCR_BUS_IDLE;
      end
    endcase
  end

  // bus state registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      bus_state <= SCR_BUS_IDLE;
      rdata <= 32'h0000_0000;
      resp <= 2'h0;
    end else begin
      bus_state <= next_bus_state;
      rdata <= next_rdata;
      resp <= next_resp;
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && (bus_state != SCR_BUS_ACK);
  assign avs_readdata_o = rdata;
  assign avs_response_o = resp;

  // register updates from bus writes and hardware
  always_comb begin
    next_k_value = k_value;
    next_m_required = m_required;
    next_m_blank = m_blank;
    next_switch_cfg = switch_cfg;
    next_delay_length = delay_length;
    if (wr_go) begin
      case (sel)
        SCR_SEL_K_VALUE: next_k_value = merge16(k_value, avs_writedata_i, avs_byteenable_i);
        SCR_SEL_M_REQUIRED: next_m_required = merge16(m_required, avs_writedata_i, avs_byteenable_i);
        SCR_SEL_M_BLANK: next_m_blank = merge16(m_blank, avs_writedata_i, avs_byteenable_i);
        SCR_SEL_SWITCH_CFG: next_switch_cfg = wr_cfg & SCR_CFG_WR_MASK;
        default: next_switch_cfg = switch_cfg; // delay length ignores writes
      endcase
    end
    // self-clear once each sequence has finished; a new write of one wins
    if (hard_done && !hard_set) begin
      next_switch_cfg[SCR_POS_HARD_RESET] = 1'b0;
    end
    if (soft_done && !soft_set) begin
      next_switch_cfg[SCR_POS_SOFT_RESET] = 1'b0;
    end
    if (rx_delay_length_valid_i) begin
      next_delay_length = rx_delay_length_i;
    end
    // end of a hard reset: every setting falls back, only a fresh reset request survives
    if (bank_rst) begin
      next_k_value = SCR_RST_RX_K_VALUE;
      next_m_required = SCR_RST_RX_M_REQUIRED;
      next_m_blank = SCR_RST_RX_M_BLANK;
      next_delay_length = SCR_RST_DELAY_LENGTH;
      next_switch_cfg = SCR_RST_SWITCH_CFG;
      if (hard_set) begin
        next_switch_cfg[SCR_POS_HARD_RESET] = 1'b1; // set wins
      end
      if (soft_set) begin
        next_switch_cfg[SCR_POS_SOFT_RESET] = 1'b1; // set wins
      end
    end
  end

  // register bank; hard reset fall-back comes through the next values, soft keeps all
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      k_value <= SCR_RST_RX_K_VALUE;
      m_required <= SCR_RST_RX_M_REQUIRED;
      m_blank <= SCR_RST_RX_M_BLANK;
      switch_cfg <= SCR_RST_SWITCH_CFG;
      delay_length <= SCR_RST_DELAY_LENGTH;
    end else begin
      k_value <= next_k_value;
      m_required <= next_m_required;
      m_blank <= next_m_blank;
      switch_cfg <= next_switch_cfg;
      delay_length <= next_delay_length;
    end
  end

  // register settings fall back at the end of a hard reset
  assign bank_rst = hard_done;
  // a hard reset also stops a soft sequence in flight
  assign soft_seq_rst = srst_i || hard_active;
  assign hard_start = switch_cfg[SCR_POS_HARD_RESET] && !hard_active && !hard_done;
  assign soft_start = switch_cfg[SCR_POS_SOFT_RESET] && !soft_active && !soft_done;

  // hard reset sequencer
  scr_reset_seq u_hard_seq (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .start_i(hard_start),
    .active_o(hard_active),
    .done_o(hard_done)
  );

  // soft reset sequencer
  scr_reset_seq u_soft_seq (
    .ref_clk_i(ref_clk_i),
    .srst_i(soft_seq_rst),
    .start_i(soft_start),
    .active_o(soft_active),
    .done_o(soft_done)
  );

  // outputs to the delay unit and switch core
  scr_core_ctl_s core_ctl;
  scr_core_ctl_s next_core_ctl;
  scr_delay_cfg_s delay_cfg;
  scr_delay_cfg_s next_delay_cfg;

  // forwarding held off during any reset; port enables are the inverted disables
  always_comb begin
    next_core_ctl.switch_enable = switch_cfg[SCR_POS_SWITCH_ENABLE] && !hard_active && !soft_active;
    next_core_ctl.port_enable = ~switch_cfg[SCR_POS_PORT_DIS_LO +: SCR_NUM_PORTS];
    next_core_ctl.hard_reset = hard_active;
    next_core_ctl.soft_reset = soft_active || hard_active;
    next_delay_cfg = {k_value, m_required, m_blank};
  end

  // core controls and delay settings registered
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      core_ctl <= '0;
      delay_cfg <= {SCR_RST_RX_K_VALUE, SCR_RST_RX_M_REQUIRED, SCR_RST_RX_M_BLANK};
    end else begin
      core_ctl <= next_core_ctl;
      delay_cfg <= next_delay_cfg;
    end
  end

  assign core_ctl_o = core_ctl;
  assign rx_delay_cfg_o = delay_cfg;

endmodule : scr_switch_cfg_regs

// file: tb/scr_delay_unit_model.sv
// far-side delay unit: posts a measured length when told to
`timescale 1ns/10ps
module scr_delay_unit_model (
  input wire logic ref_clk_i,
  input wire logic upd_i,
  input wire logic [5:0] val_i,
  output logic [5:0] len_o,
  output logic valid_o
);
  // length line toggles while not qualified so stale data never looks valid
  always_ff @(posedge ref_clk_i) begin
    valid_o <= upd_i;
    len_o <= upd_i ? val_i : ~len_o;
  end
endmodule : scr_delay_unit_model

// file: tb/scr_switch_cfg_regs_monitor.sv
// checker: handshake, field and strobe properties of the config bank
`timescale 1ns/10ps
module scr_switch_cfg_regs_monitor
  import scr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic [SCR_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire scr_delay_cfg_s rx_delay_cfg_o,
  input wire scr_core_ctl_s core_ctl_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  // decoded bus events
  logic req, wr_ok, rd_ok, unmapped;
  assign req = avs_read_i | avs_write_i;
  assign wr_ok = avs_write_i & ~avs_waitrequest_o & (avs_byteenable_i[1:0] == 2'h3);
  assign rd_ok = avs_read_i & ~avs_waitrequest_o;
  assign unmapped = !(avs_address_i[17:2] inside {SCR_IDX_RX_K_VALUE, SCR_IDX_RX_M_REQUIRED,
    SCR_IDX_RX_M_BLANK, SCR_IDX_RX_DELAY_LENGTH, SCR_IDX_SWITCH_CFG}) || avs_address_i[1:0] != 2'h0;
  property p_wait;
    req && !$past(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state count wrong");
  property p_se_off;
    core_ctl_o.hard_reset || core_ctl_o.soft_reset |-> !core_ctl_o.switch_enable;
  endproperty
  a_se_off: assert property (p_se_off) else $error("forwarding on during reset");
  property p_port;
    wr_ok && avs_address_i[17:2] == SCR_IDX_SWITCH_CFG |->
      ##2 core_ctl_o.port_enable == ~$past(avs_writedata_i[14:8], 2);
  endproperty
  a_port: assert property (p_port) else $error("port enables wrong");
  property p_k_value;
    wr_ok && avs_address_i[17:2] == SCR_IDX_RX_K_VALUE |->
      ##2 rx_delay_cfg_o.k_value == $past(avs_writedata_i[15:0], 2);
  endproperty
  a_k_value: assert property (p_k_value) else $error("k value not passed on");
  property p_rsvd;
    rd_ok && avs_address_i[17:2] == SCR_IDX_SWITCH_CFG |->
      avs_readdata_o[7:2] == 6'h00 && avs_readdata_o[31:16] == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_unmap;
    rd_ok && unmapped |-> avs_response_o == 2'h3 && avs_readdata_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_soft;
    $rose(core_ctl_o.soft_reset) && !core_ctl_o.hard_reset |->
      core_ctl_o.soft_reset[*4] ##1 !core_ctl_o.soft_reset;
  endproperty
  a_soft: assert property (p_soft) else $error("soft strobe length wrong");
  property p_hard;
    $fell(core_ctl_o.hard_reset) |->
      ##[0:3] rx_delay_cfg_o == {SCR_RST_RX_K_VALUE, SCR_RST_RX_M_REQUIRED, SCR_RST_RX_M_BLANK};
  endproperty
  a_hard: assert property (p_hard) else $error("settings kept after hard reset");
endmodule : scr_switch_cfg_regs_monitor

bind scr_switch_cfg_regs scr_switch_cfg_regs_monitor u_mon (.*);

// file: tb/tb_switch_cfg_and_rx_delay_regs.sv
// testbench: random and corner-case register traffic for the config bank
`timescale 1ns/10ps
module tb_switch_cfg_and_rx_delay_regs;
  import scr_pkg::*;
  logic ref_clk_i = 1'b0, srst_i = 1'b1, rd = 1'b0, wr = 1'b0, upd = 1'b0, wt, lvld;
  logic [17:0] addr = '0;
  logic [31:0] wdat = '0, rdata, rdat;
  logic [3:0] be = 4'hF;
  logic [1:0] resp, rrsp;
  logic [5:0] len, uval = '0;
  logic [15:0] d;
  logic [15:0] sh [3];
  scr_delay_cfg_s dcfg;
  scr_core_ctl_s ctl;
  int failures = 0, n_checks = 0;
  localparam logic [15:0] IX [5] = '{SCR_IDX_RX_K_VALUE, SCR_IDX_RX_M_REQUIRED, SCR_IDX_RX_M_BLANK,
    SCR_IDX_RX_DELAY_LENGTH, SCR_IDX_SWITCH_CFG};
  localparam logic [15:0] RV [5] = '{16'h0040, 16'h0000, 16'h0002, 16'h0000, 16'h0000};
  scr_switch_cfg_regs u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .avs_response_o(resp), .rx_delay_length_i(len),
    .rx_delay_length_valid_i(lvld), .rx_delay_cfg_o(dcfg), .core_ctl_o(ctl));
  scr_delay_unit_model u_far (.ref_clk_i(ref_clk_i), .upd_i(upd), .val_i(uval), .len_o(len), .valid_o(lvld));
  // clock
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task chk(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : test_done
  // one bus transfer, held until waitrequest drops
  task xfer(input logic [15:0] ix, input logic w, input logic [15:0] dat);
    int i;
    @(posedge ref_clk_i);
    addr <= {ix, 2'b00};
    wdat <= {16'h0000, dat};
    wr <= w;
    rd <= ~w;
    i = 0;
    do begin
      @(posedge ref_clk_i);
      i++;
    end while (wt !== 1'b0 && i < 20);
    rdat = rdata;
    rrsp = resp;
    wr <= 1'b0;
    rd <= 1'b0;
    if (wt !== 1'b0) begin
      failures++;
      test_done();
    end
  endtask : xfer
  // every register against its reset value
  task chk_rst;
    for (int j = 0; j < 5; j++) begin
      xfer(IX[j], 1'b0, 16'h0000);
      chk(48'({rrsp, rdat}), 48'({2'b00, 16'h0000, RV[j]}));
    end
  endtask : chk_rst
  // main sequence
  initial begin
    void'($urandom(32'h0B29));
    repeat (6) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    chk_rst();
    repeat (6) begin
      for (int j = 0; j < 3; j++) begin
        sh[j] = 16'($urandom);
        xfer(IX[j], 1'b1, sh[j]);
        xfer(IX[j], 1'b0, 16'h0000);
        chk(48'(rdat), 48'(sh[j]));
      end
      chk(dcfg, {sh[0], sh[1], sh[2]});
    end
    // low byte only under byte enables
    be <= 4'h1;
    xfer(IX[0], 1'b1, ~sh[0]);
    be <= 4'hF;
    xfer(IX[0], 1'b0, 16'h0000);
    chk(48'(rdat), 48'({sh[0][15:8], ~sh[0][7:0]}));
    d = 16'($urandom);
    @(posedge ref_clk_i);
    uval <= d[5:0];
    upd <= 1'b1;
    @(posedge ref_clk_i);
    upd <= 1'b0;
    xfer(IX[3], 1'b1, 16'hFFFF);
    xfer(IX[3], 1'b0, 16'h0000);
    chk(48'(rdat), 48'(d[5:0]));
    // ports set up while forwarding is off, reserved bits written as ones
    d = 16'($urandom) & 16'h7FFC | 16'h00FC;
    xfer(IX[4], 1'b1, d);
    xfer(IX[4], 1'b0, 16'h0000);
    chk(48'(rdat), 48'(d & 16'hFF00));
    #1;
    chk(48'(ctl), 48'({1'b0, ~d[14:8], 2'b00}));
    xfer(IX[4], 1'b1, d | 16'h8000);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(48'(ctl), 48'({1'b1, ~d[14:8], 2'b00}));
    xfer(IX[4], 1'b1, d | 16'h8001);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(48'(ctl), 48'({1'b0, ~d[14:8], 2'b01}));
    repeat (8) @(posedge ref_clk_i);
    xfer(IX[4], 1'b0, 16'h0000);
    chk(48'(rdat), 48'((d | 16'h8000) & 16'hFF00));
    xfer(IX[2], 1'b0, 16'h0000);
    chk(48'(rdat), 48'(sh[2]));
    xfer(IX[4], 1'b1, 16'h0002);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(48'(ctl), 48'({1'b0, 7'h7F, 2'b11}));
    repeat (7) @(posedge ref_clk_i);
    chk_rst();
    xfer(16'hF16C, 1'b0, 16'h0000);
    chk(48'({rrsp, rdat}), 48'({2'b11, 32'h0}));
    test_done();
  end
endmodule : tb_switch_cfg_and_rx_delay_regs
